// >>> bsf_pkg.sv
// Constants and types for the bit, shift and flag datapath
package bsf_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 7;
   localparam int IDX_W     = 5;
   localparam int BIT_W     = 3;
   localparam int WREG_N    = 32;
   localparam int IO_N      = 32;

   // ----------------------------------------------------------------
   // Register map (page codes for address bits 6:5, status byte address)
   // ----------------------------------------------------------------
   localparam logic [1:0] ADR_WREG_PAGE = 2'h0;
   localparam logic [1:0] ADR_IO_PAGE   = 2'h1;
   localparam logic [6:0] ADR_STATUS    = 7'h40;

   // ----------------------------------------------------------------
   // Status register bit positions and reset value
   // ----------------------------------------------------------------
   localparam logic [2:0] FLAG_C        = 3'h0;
   localparam logic [2:0] FLAG_Z        = 3'h1;
   localparam logic [2:0] FLAG_N        = 3'h2;
   localparam logic [2:0] FLAG_V        = 3'h3;
   localparam logic [2:0] FLAG_T        = 3'h6;
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] DATA_RESET    = 8'h00;

   // ----------------------------------------------------------------
   // Timing in clock cycles
   // ----------------------------------------------------------------
   localparam int IO_OP_CYCLES  = 2;
   localparam int ONE_OP_CYCLES = 1;

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      no_op                   = 5'h00,
      io_bit_set_op           = 5'h01,
      io_bit_clear_op         = 5'h02,
      logical_left_shift_op   = 5'h03,
      logical_right_shift_op  = 5'h04,
      rotate_left_carry_op    = 5'h05,
      rotate_right_carry_op   = 5'h06,
      arith_right_shift_op    = 5'h07,
      nibble_swap_op          = 5'h08,
      status_bit_set_op       = 5'h09,
      status_bit_clear_op     = 5'h0a,
      bit_to_transfer_flag_op = 5'h0b,
      transfer_flag_to_bit_op = 5'h0c,
      carry_set_op            = 5'h0d,
      carry_clear_op          = 5'h0e,
      negative_set_op         = 5'h0f,
      negative_clear_op       = 5'h10,
      zero_set_op             = 5'h11,
      zero_clear_op           = 5'h12
   } bsf_op_t;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      st_idle     = 2'b01,
      st_io_write = 2'b10
   } bsf_state_t;

endpackage : bsf_pkg

// >>> bsf_shifter.sv
// Combinational shift, rotate and nibble exchange unit
module bsf_shifter
   import bsf_pkg::*;
(
   // Operation
   input  wire bsf_op_t           i_op,
   input  wire logic [DATA_W-1:0] i_value,
   input  wire logic              i_carry,
   // Result
   output logic      [DATA_W-1:0] o_result,
   output logic                   o_carry,
   output logic                   o_is_shift,
   output logic                   o_writes
);

   always_comb begin
      o_result   = i_value;
      o_carry    = i_carry;
      o_is_shift = 1'b1;
      o_writes   = 1'b1;
      unique case (i_op)
         logical_left_shift_op: begin
            o_result = {i_value[6:0], 1'b0};
            o_carry  = i_value[7];
         end
         logical_right_shift_op: begin
            o_result = {1'b0, i_value[7:1]};
            o_carry  = i_value[0];
         end
         rotate_left_carry_op: begin
            o_result = {i_value[6:0], i_carry};
            o_carry  = i_value[7];
         end
         rotate_right_carry_op: begin
            o_result = {i_carry, i_value[7:1]};
            o_carry  = i_value[0];
         end
         arith_right_shift_op: begin
            o_result = {i_value[7], i_value[7:1]};
            o_carry  = i_value[0];
         end
         nibble_swap_op: begin
            o_result   = {i_value[3:0], i_value[7:4]};
            o_is_shift = 1'b0;
         end
         default: begin
            o_is_shift = 1'b0;
            o_writes   = 1'b0;
         end
      endcase
   end

endmodule : bsf_shifter

// >>> bsf_unit.sv
// Bit manipulation, shift and status flag datapath with register port
//
// What this block does
// - Set I/O bit forces selected bit to one, no flags, two cycles.
// - Clear I/O bit forces selected bit to zero, no flags, two cycles.
// - Logical left shift moves bits up, zero into bit 0, one cycle.
// - Logical right shift moves bits down, zero into bit 7, one cycle.
// - Left rotate: old carry into bit 0, old bit 7 into carry.
// - Right rotate: old carry into bit 7, old bit 0 into carry.
// - Arithmetic right shift moves bits down, keeps bit 7.
// - Nibble exchange swaps low and high halves, no flags, one cycle.
// - Status bit set writes one to the indexed status bit only.
// - Status bit clear writes zero to the indexed status bit only.
// - Bit store copies source register bit into transfer flag only.
// - Bit load copies transfer flag into destination bit, no flags.
// - Carry set and clear touch only carry, one cycle each.
// - Negative set and clear touch only negative, one cycle each.
// - Zero set and clear touch only zero, one cycle each.
// - Shifts and rotates update zero, carry, negative and overflow.
//
// The placing of the registers and the plain strobed port were decided locally.
module bsf_unit
   import bsf_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   output logic      [DATA_W-1:0] o_rd_data,
   // Operation port from the decoder
   input  wire logic              i_op_valid,
   input  wire bsf_op_t           i_op_code,
   input  wire logic [IDX_W-1:0]  i_op_dst,
   input  wire logic [IDX_W-1:0]  i_op_src,
   input  wire logic [IDX_W-1:0]  i_op_io,
   input  wire logic [BIT_W-1:0]  i_op_bit,
   output logic                   o_op_ready,
   output logic                   o_op_done,
   // Status view
   output logic      [DATA_W-1:0] o_status
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] wreg   [WREG_N];
   logic [DATA_W-1:0] io_mem [IO_N];
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] next_status;
   bsf_state_t        state;
   bsf_state_t        next_state;
   logic [IDX_W-1:0]  io_idx;
   logic [DATA_W-1:0] io_mask;
   logic              io_set;
   logic              next_done;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire               sel_wreg    = (i_addr[6:5] == ADR_WREG_PAGE);
   wire               sel_io      = (i_addr[6:5] == ADR_IO_PAGE);
   wire               sel_status  = (i_addr == ADR_STATUS);
   wire               bus_wr_wreg = i_wr_en && sel_wreg;
   wire               bus_wr_io   = i_wr_en && sel_io;
   wire               bus_wr_stat = i_wr_en && sel_status;
   wire [DATA_W-1:0]  rd_mux      = sel_wreg   ? wreg[i_addr[4:0]]   :
                                    sel_io     ? io_mem[i_addr[4:0]] :
                                    sel_status ? status              : 8'h00;

   // ----------------------------------------------------------------
   // Operation decode
   // ----------------------------------------------------------------
   wire               op_take     = i_op_valid && o_op_ready;
   wire               op_is_io    = (i_op_code == io_bit_set_op) ||
                                    (i_op_code == io_bit_clear_op);
   wire [DATA_W-1:0]  bit_mask    = 8'h01 << i_op_bit;
   wire [DATA_W-1:0]  dst_val     = wreg[i_op_dst];
   wire [DATA_W-1:0]  src_val     = wreg[i_op_src];
   wire               src_bit     = src_val[i_op_bit];
   wire [DATA_W-1:0]  load_val    = (dst_val & ~bit_mask) |
                                    ({DATA_W{status[FLAG_T]}} & bit_mask);
   wire [DATA_W-1:0]  sh_result;
   wire               sh_carry;
   wire               sh_is_shift;
   wire               sh_writes;
   wire               op_wreg_we  = op_take &&
                                    (sh_writes || (i_op_code == transfer_flag_to_bit_op));
   wire [DATA_W-1:0]  op_wreg_val = sh_writes ? sh_result : load_val;
   wire [DATA_W-1:0]  io_cur      = io_mem[io_idx];
   wire [DATA_W-1:0]  io_new      = io_set ? (io_cur | io_mask)
                                           : (io_cur & ~io_mask);

   bsf_shifter u_shifter (
      .i_op       (i_op_code),
      .i_value    (dst_val),
      .i_carry    (status[FLAG_C]),
      .o_result   (sh_result),
      .o_carry    (sh_carry),
      .o_is_shift (sh_is_shift),
      .o_writes   (sh_writes)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign o_op_ready = (state == st_idle);
   assign next_state = (op_take && op_is_io) ? st_io_write : st_idle;
   assign next_done  = (op_take && !op_is_io) || (state == st_io_write);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state     <= st_idle;
         o_op_done <= 1'b0;
      end else begin
         state     <= next_state;
         o_op_done <= next_done;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         io_idx  <= '0;
         io_mask <= '0;
         io_set  <= 1'b0;
      end else if (op_take && op_is_io) begin
         io_idx  <= i_op_io;
         io_mask <= bit_mask;
         io_set  <= (i_op_code == io_bit_set_op);
      end
   end

   // ----------------------------------------------------------------
   // Status register next value
   // ----------------------------------------------------------------
   always_comb begin
      next_status = bus_wr_stat ? i_wr_data : status;
      if (op_take) begin
         unique case (i_op_code)
            logical_left_shift_op, logical_right_shift_op,
            rotate_left_carry_op, rotate_right_carry_op,
            arith_right_shift_op: begin
               next_status[FLAG_C] = sh_carry;
               next_status[FLAG_Z] = (sh_result == 8'h00);
               next_status[FLAG_N] = sh_result[7];
               next_status[FLAG_V] = sh_result[7] ^ sh_carry;
            end
            status_bit_set_op:       next_status = next_status | bit_mask;
            status_bit_clear_op:     next_status = next_status & ~bit_mask;
            bit_to_transfer_flag_op: next_status[FLAG_T] = src_bit;
            carry_set_op:            next_status[FLAG_C] = 1'b1;
            carry_clear_op:          next_status[FLAG_C] = 1'b0;
            negative_set_op:         next_status[FLAG_N] = 1'b1;
            negative_clear_op:       next_status[FLAG_N] = 1'b0;
            zero_set_op:             next_status[FLAG_Z] = 1'b1;
            zero_clear_op:           next_status[FLAG_Z] = 1'b0;
            default:                 next_status = next_status;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         status <= STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   assign o_status = status;

   // ----------------------------------------------------------------
   // Working registers, operation write wins over bus write
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < WREG_N; i++) begin
            wreg[i] <= DATA_RESET;
         end
      end else begin
         if (bus_wr_wreg) begin
            wreg[i_addr[4:0]] <= i_wr_data;
         end
         if (op_wreg_we) begin
            wreg[i_op_dst] <= op_wreg_val;
         end
      end
   end

   // ----------------------------------------------------------------
   // I/O registers, read-modify-write in the second cycle
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < IO_N; i++) begin
            io_mem[i] <= DATA_RESET;
         end
      end else begin
         if (bus_wr_io) begin
            io_mem[i_addr[4:0]] <= i_wr_data;
         end
         if (state == st_io_write) begin
            io_mem[io_idx] <= io_new;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rd_data <= 8'h00;
      end else begin
         o_rd_data <= i_rd_en ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   wire no_stat_wr = !bus_wr_stat;

   property p_io_set;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == io_bit_set_op) |=>
         !o_op_ready ##1 (o_op_ready && o_op_done &&
         io_mem[$past(i_op_io, 2)][$past(i_op_bit, 2)] == 1'b1);
   endproperty
   a_io_set: assert property (p_io_set) else $error("io bit set failed");

   property p_io_clear;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == io_bit_clear_op && no_stat_wr) |->
         ##1 (status == $past(status)) ##1
         (o_op_done && io_mem[$past(i_op_io, 2)][$past(i_op_bit, 2)] == 1'b0);
   endproperty
   a_io_clear: assert property (p_io_clear) else $error("io bit clear failed");

   property p_lsl;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == logical_left_shift_op) |=>
         (wreg[$past(i_op_dst)] == {$past(dst_val[6:0]), 1'b0}) && o_op_done;
   endproperty
   a_lsl: assert property (p_lsl) else $error("left shift result wrong");

   property p_lsr;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == logical_right_shift_op) |=>
         wreg[$past(i_op_dst)] == {1'b0, $past(dst_val[7:1])};
   endproperty
   a_lsr: assert property (p_lsr) else $error("right shift result wrong");

   property p_rol;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == rotate_left_carry_op) |=>
         (wreg[$past(i_op_dst)] == {$past(dst_val[6:0]), $past(status[FLAG_C])}) &&
         (status[FLAG_C] == $past(dst_val[7]));
   endproperty
   a_rol: assert property (p_rol) else $error("left rotate wrong");

   property p_ror;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == rotate_right_carry_op) |=>
         (wreg[$past(i_op_dst)] == {$past(status[FLAG_C]), $past(dst_val[7:1])}) &&
         (status[FLAG_C] == $past(dst_val[0]));
   endproperty
   a_ror: assert property (p_ror) else $error("right rotate wrong");

   property p_asr;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == arith_right_shift_op) |=>
         wreg[$past(i_op_dst)] == {$past(dst_val[7]), $past(dst_val[7:1])};
   endproperty
   a_asr: assert property (p_asr) else $error("arith shift wrong");

   property p_swap;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == nibble_swap_op && no_stat_wr) |=>
         (wreg[$past(i_op_dst)] == {$past(dst_val[3:0]), $past(dst_val[7:4])}) &&
         $stable(status);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong");

   property p_flag_bit;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && no_stat_wr && (i_op_code == status_bit_set_op ||
         i_op_code == status_bit_clear_op)) |=>
         status == ($past(i_op_code) == status_bit_set_op ?
                    ($past(status) | $past(bit_mask)) : ($past(status) & ~$past(bit_mask)));
   endproperty
   a_flag_bit: assert property (p_flag_bit) else $error("status bit op wrong");

   property p_bst;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == bit_to_transfer_flag_op && no_stat_wr) |=>
         (status[FLAG_T] == $past(src_bit)) &&
         ((status ^ $past(status)) & ~(8'h01 << FLAG_T)) == 8'h00;
   endproperty
   a_bst: assert property (p_bst) else $error("bit store wrong");

   property p_bld;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == transfer_flag_to_bit_op) |=>
         wreg[$past(i_op_dst)] == $past(load_val);
   endproperty
   a_bld: assert property (p_bld) else $error("bit load wrong");

   property p_dedicated;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && no_stat_wr && i_op_code == carry_set_op) |=>
         status == ($past(status) | 8'h01) && o_op_done;
   endproperty
   a_dedicated: assert property (p_dedicated) else $error("carry set wrong");

   property p_carry_clear;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && no_stat_wr && i_op_code == carry_clear_op) |=>
         status == ($past(status) & ~(8'h01 << FLAG_C)) && o_op_done;
   endproperty
   a_carry_clear: assert property (p_carry_clear) else $error("carry clear wrong");

   property p_neg_flag;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && no_stat_wr && (i_op_code == negative_set_op ||
         i_op_code == negative_clear_op)) |=>
         status == ($past(i_op_code) == negative_set_op ?
                    ($past(status) | (8'h01 << FLAG_N)) : ($past(status) & ~(8'h01 << FLAG_N)));
   endproperty
   a_neg_flag: assert property (p_neg_flag) else $error("negative flag op wrong");

   property p_zero_flag;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && no_stat_wr && (i_op_code == zero_set_op ||
         i_op_code == zero_clear_op)) |=>
         status == ($past(i_op_code) == zero_set_op ?
                    ($past(status) | (8'h01 << FLAG_Z)) : ($past(status) & ~(8'h01 << FLAG_Z)));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag op wrong");

   property p_shift_flags;
      @(posedge i_clk) disable iff (i_rst)
      (op_take && sh_is_shift) |=>
         (status[FLAG_Z] == (wreg[$past(i_op_dst)] == 8'h00)) &&
         (status[FLAG_N] == wreg[$past(i_op_dst)][7]) &&
         (status[FLAG_V] == (status[FLAG_N] ^ status[FLAG_C]));
   endproperty
   a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");

   c_io_set: cover property (@(posedge i_clk) disable iff (i_rst)
      op_take && i_op_code == io_bit_set_op ##2 o_op_done);
   c_rol: cover property (@(posedge i_clk) disable iff (i_rst)
      op_take && i_op_code == rotate_left_carry_op && status[FLAG_C]);
   c_bst_bld: cover property (@(posedge i_clk) disable iff (i_rst)
      (op_take && i_op_code == bit_to_transfer_flag_op) ##1
      (op_take && i_op_code == transfer_flag_to_bit_op));

endmodule : bsf_unit

// >>> tb.sv
// Self-checking testbench for the bit, shift and flag datapath
module tb
   import bsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              i_clk;
   logic              i_rst;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wr_data;
   logic              i_wr_en;
   logic              i_rd_en;
   logic [DATA_W-1:0] o_rd_data;
   logic              i_op_valid;
   bsf_op_t           i_op_code;
   logic [IDX_W-1:0]  i_op_dst;
   logic [IDX_W-1:0]  i_op_src;
   logic [IDX_W-1:0]  i_op_io;
   logic [BIT_W-1:0]  i_op_bit;
   logic              o_op_ready;
   logic              o_op_done;
   logic [DATA_W-1:0] o_status;
   int                fail_count;
   int                tests_run;
   logic [7:0]        rd;
   logic [7:0]        pre;
   logic [7:0]        expv;
   logic [8:0]        cr;
   bsf_op_t           sh_ops [5];
   logic [7:0]        sh_vals [3];
   bsf_op_t           fl_ops [6];
   logic [2:0]        fl_pos [6];

   bsf_unit bsf_unit_inst (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_addr     (i_addr),
      .i_wr_data  (i_wr_data),
      .i_wr_en    (i_wr_en),
      .i_rd_en    (i_rd_en),
      .o_rd_data  (o_rd_data),
      .i_op_valid (i_op_valid),
      .i_op_code  (i_op_code),
      .i_op_dst   (i_op_dst),
      .i_op_src   (i_op_src),
      .i_op_io    (i_op_io),
      .i_op_bit   (i_op_bit),
      .o_op_ready (o_op_ready),
      .o_op_done  (o_op_done),
      .o_status   (o_status)
   );

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      $display("ERROR watchdog expected 00 seen 01");
      fail_count++;
      test_done();
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic bus_wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr_en   <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_clk);
      i_wr_en   <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_addr  <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1 d = o_rd_data;
   endtask : bus_rd

   // Io ops get a refused carry set in their busy cycle
   task automatic do_op(input bsf_op_t code, input logic [4:0] dst, input logic [4:0] src,
                        input logic [4:0] io, input logic [2:0] b);
      @(posedge i_clk);
      i_op_valid <= 1'b1;
      i_op_code  <= code;
      i_op_dst   <= dst;
      i_op_src   <= src;
      i_op_io    <= io;
      i_op_bit   <= b;
      @(posedge i_clk);
      if (code == io_bit_set_op || code == io_bit_clear_op) begin
         i_op_code <= carry_set_op;
         #1 check("busy_ready", {7'h0, o_op_ready}, 8'h00);
         check("busy_done", {7'h0, o_op_done}, 8'h00);
         @(posedge i_clk);
      end
      i_op_valid <= 1'b0;
      #1 check("op_done", {7'h0, o_op_done}, 8'h01);
   endtask : do_op

   function automatic logic [8:0] exp_shift(input bsf_op_t op, input logic [7:0] v,
                                            input logic cin);
      case (op)
         logical_left_shift_op:  return {v[7], v[6:0], 1'b0};
         logical_right_shift_op: return {v[0], 1'b0, v[7:1]};
         rotate_left_carry_op:   return {v[7], v[6:0], cin};
         rotate_right_carry_op:  return {v[0], cin, v[7:1]};
         default:                return {v[0], v[7], v[7:1]};
      endcase
   endfunction : exp_shift

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      fail_count = 0;
      tests_run  = 0;
      i_rst      = 1'b1;
      i_addr     = 7'h00;
      i_wr_data  = 8'h00;
      i_wr_en    = 1'b0;
      i_rd_en    = 1'b0;
      i_op_valid = 1'b0;
      i_op_code  = no_op;
      i_op_dst   = 5'h00;
      i_op_src   = 5'h00;
      i_op_io    = 5'h00;
      i_op_bit   = 3'h0;
      sh_ops  = '{logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
                  rotate_right_carry_op, arith_right_shift_op};
      sh_vals = '{8'h81, 8'h00, 8'h7e};
      fl_ops  = '{carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
                  zero_set_op, zero_clear_op};
      fl_pos  = '{FLAG_C, FLAG_C, FLAG_N, FLAG_N, FLAG_Z, FLAG_Z};
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      bus_rd(7'h40, rd);
      check("status_reset", rd, 8'h00);
      @(posedge i_clk);
      #1 check("rd_idle", o_rd_data, 8'h00);
      // Unmapped address
      bus_wr(7'h41, 8'hff);
      bus_rd(7'h41, rd);
      check("unmapped", rd, 8'h00);
      // Io bit set and clear
      bus_wr(7'h25, 8'ha5);
      bus_wr(7'h40, 8'h5a);
      do_op(io_bit_set_op, 5'h00, 5'h00, 5'h05, 3'h1);
      check("io_set_status", o_status, 8'h5a);
      bus_rd(7'h25, rd);
      check("io_set", rd, 8'ha7);
      do_op(io_bit_clear_op, 5'h00, 5'h00, 5'h05, 3'h7);
      check("io_clr_status", o_status, 8'h5a);
      bus_rd(7'h25, rd);
      check("io_clr", rd, 8'h27);
      // Shifts and rotates
      for (int o = 0; o < 5; o++) begin
         for (int v = 0; v < 6; v++) begin
            pre = 8'hb0 | {7'h0, v[0]};
            bus_wr(7'h03, sh_vals[v/2]);
            bus_wr(7'h40, pre);
            do_op(sh_ops[o], 5'h03, 5'h00, 5'h00, 3'h0);
            cr = exp_shift(sh_ops[o], sh_vals[v/2], v[0]);
            expv = {pre[7:4], cr[7] ^ cr[8], cr[7], cr[7:0] == 8'h00, cr[8]};
            check("shift_flags", o_status, expv);
            bus_rd(7'h03, rd);
            check("shift_result", rd, cr[7:0]);
         end
      end
      // Nibble exchange
      bus_wr(7'h09, 8'h3c);
      bus_wr(7'h40, 8'h5a);
      do_op(nibble_swap_op, 5'h09, 5'h00, 5'h00, 3'h0);
      check("swap_status", o_status, 8'h5a);
      bus_rd(7'h09, rd);
      check("swap", rd, 8'hc3);
      // Generic status set and clear, every index
      for (int b = 0; b < 8; b++) begin
         bus_wr(7'h40, ~(8'h01 << b));
         do_op(status_bit_set_op, 5'h00, 5'h00, 5'h00, b[2:0]);
         check("status_set", o_status, 8'hff);
         do_op(status_bit_clear_op, 5'h00, 5'h00, 5'h00, b[2:0]);
         check("status_clr", o_status, ~(8'h01 << b));
      end
      // Bit store and bit load
      bus_wr(7'h04, 8'h20);
      bus_wr(7'h40, 8'h8f);
      do_op(bit_to_transfer_flag_op, 5'h00, 5'h04, 5'h00, 3'h5);
      check("store_one", o_status, 8'hcf);
      do_op(bit_to_transfer_flag_op, 5'h00, 5'h04, 5'h00, 3'h4);
      check("store_zero", o_status, 8'h8f);
      bus_wr(7'h07, 8'hf0);
      do_op(transfer_flag_to_bit_op, 5'h07, 5'h00, 5'h00, 3'h6);
      bus_rd(7'h07, rd);
      check("load_zero", rd, 8'hb0);
      bus_wr(7'h40, 8'h40);
      do_op(transfer_flag_to_bit_op, 5'h07, 5'h00, 5'h00, 3'h3);
      check("load_status", o_status, 8'h40);
      bus_rd(7'h07, rd);
      check("load_one", rd, 8'hb8);
      // Dedicated flag operations
      for (int i = 0; i < 6; i++) begin
         pre = i[0] ? 8'hf7 : 8'h28;
         expv = pre;
         expv[fl_pos[i]] = ~i[0];
         bus_wr(7'h40, pre);
         do_op(fl_ops[i], 5'h00, 5'h00, 5'h00, 3'h0);
         check("flag_op", o_status, expv);
      end
      // Empty code only pulses done
      do_op(no_op, 5'h07, 5'h07, 5'h05, 3'h0);
      check("no_op_status", o_status, expv);
      bus_rd(7'h07, rd);
      check("no_op_reg", rd, 8'hb8);
      test_done();
   end

endmodule : tb
